// File: drs_pkg.sv
// Constants, register map and state type of the drive restart and brake sequencer.
package drs_pkg;

    localparam int CLK_HZ        = 40_000_000;
    localparam int SUB_TICK_HZ   = 800;
    localparam int SUB_TICK_CYC  = CLK_HZ / SUB_TICK_HZ;
    localparam int SUB_PER_TICK  = 8;
    localparam int TICK_PER_SEC  = 100;
    localparam int TICK_PER_DSEC = 10;

    localparam int AW   = 5;
    localparam int DW   = 16;
    localparam int NCFG = 21;

    // Settings registers, all read and write.
    localparam logic [AW-1:0] REG_TQ_TC     = 5'h00;
    localparam logic [AW-1:0] REG_SLIP_TC   = 5'h01;
    localparam logic [AW-1:0] REG_DCB_LVL   = 5'h02;
    localparam logic [AW-1:0] REG_DCB_T_RUN = 5'h03;
    localparam logic [AW-1:0] REG_DCB_T_STP = 5'h04;
    localparam logic [AW-1:0] REG_DCB_FREQ  = 5'h05;
    localparam logic [AW-1:0] REG_PL_SEL    = 5'h06;
    localparam logic [AW-1:0] REG_PL_MAX_T  = 5'h07;
    localparam logic [AW-1:0] REG_BLK_T     = 5'h08;
    localparam logic [AW-1:0] REG_SS_ILIM   = 5'h09;
    localparam logic [AW-1:0] REG_SKIP1_HI  = 5'h0A;
    localparam logic [AW-1:0] REG_SKIP1_LO  = 5'h0B;
    localparam logic [AW-1:0] REG_SKIP2_HI  = 5'h0C;
    localparam logic [AW-1:0] REG_SKIP2_LO  = 5'h0D;
    localparam logic [AW-1:0] REG_SKIP3_HI  = 5'h0E;
    localparam logic [AW-1:0] REG_SKIP3_LO  = 5'h0F;
    localparam logic [AW-1:0] REG_AR_NUM    = 5'h10;
    localparam logic [AW-1:0] REG_AR_RST_T  = 5'h11;
    localparam logic [AW-1:0] REG_STOP_SEL  = 5'h12;
    localparam logic [AW-1:0] REG_FREQ_CMD  = 5'h13;
    localparam logic [AW-1:0] REG_FREQ_MIN  = 5'h14;
    // Recording counters (write zero clears) and read-only state.
    localparam logic [AW-1:0] REG_RUN_MIN   = 5'h15;
    localparam logic [AW-1:0] REG_RUN_DAY   = 5'h16;
    localparam logic [AW-1:0] REG_STATUS    = 5'h17;
    localparam logic [AW-1:0] REG_OUT_FREQ  = 5'h18;

    localparam logic [DW-1:0] V_ZERO      = 16'h0000;
    localparam logic [DW-1:0] V_ONE       = 16'h0001;
    localparam logic [DW-1:0] V_TWO       = 16'h0002;
    localparam logic [DW-1:0] V_THREE     = 16'h0003;
    localparam logic [DW-1:0] V_TQ_TC_MIN = 16'h0001;
    localparam logic [DW-1:0] V_TQ_TC_RST = 16'h0005;
    localparam logic [DW-1:0] V_SL_TC_MIN = 16'h0005;
    localparam logic [DW-1:0] V_SL_TC_RST = 16'h000A;
    localparam logic [DW-1:0] V_TC_MAX    = 16'h03E8;
    localparam logic [DW-1:0] V_PCT_MAX   = 16'h0064;
    localparam logic [DW-1:0] V_DCB_T_MAX = 16'h0258;
    localparam logic [DW-1:0] V_FREQ_MAX  = 16'h9C40;
    localparam logic [DW-1:0] V_PL_T_MAX  = 16'h0032;
    localparam logic [DW-1:0] V_PL_T_RST  = 16'h0014;
    localparam logic [DW-1:0] V_BLK_T_RST = 16'h0005;
    localparam logic [DW-1:0] V_ILIM_MIN  = 16'h001E;
    localparam logic [DW-1:0] V_ILIM_MAX  = 16'h00C8;
    localparam logic [DW-1:0] V_ILIM_RST  = 16'h0096;
    localparam logic [DW-1:0] V_AR_MAX    = 16'h000A;
    localparam logic [DW-1:0] V_AR_T_MAX  = 16'hEA60;
    localparam logic [DW-1:0] V_AR_T_RST  = 16'h0258;
    localparam logic [DW-1:0] V_SEC_LAST  = 16'h003B;
    localparam logic [DW-1:0] V_MIN_LAST  = 16'h059F;
    localparam logic [DW-1:0] V_SAT       = 16'hFFFF;

    // Ramp and search steps, in 0.01 Hz per 10 ms tick.
    localparam logic [DW-1:0] RAMP_STEP   = 16'h0032;
    localparam logic [DW-1:0] SEARCH_STEP = 16'h0032;

    typedef enum logic [3:0] {
        ST_IDLE, ST_DCB_START, ST_RUN, ST_DECEL, ST_DCB_STOP,
        ST_LOSS, ST_BLK_HOLD, ST_BLK_WAIT, ST_SEARCH, ST_FAULT
    } drs_state_e;

endpackage

// File: drs_sequencer.sv
// Start and stop DC brake, power-loss restart, skip bands and fault restart sequencer.
// Overview of operation
// - Torque and slip filters, separate time constants.
// - Two run-time counters, zero clears, partial minute dropped.
// - DC brake level zero to 100 percent.
// - Run command starts with timed DC brake.
// - After start brake, accelerate from minimum frequency.
// - Stop brake only for ramp stop codes.
// - Stop brake begins at configured frequency.
// - Loss code selects stop, reference or minimum.
// - Encoder fitted: search from measured speed.
// - Short loss resumes, long loss coasts.
// - Restart only if limit ok and undervoltage shown.
// - Overload power-down gives normal start instead.
// - Loss blocks output, then waits blocking time.
// - Same wait after external block and fault restart.
// - Search continues while current above limit.
// - Below limit: synchronised, ramp back to target.
// - Three skip bands, no steady output inside.
// - Auto restart only after overcurrent or overvoltage.
// - Fault restart searches from pre-fault frequency, or from measured speed with encoder.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module drs_sequencer
    import drs_pkg::*;
#(
    parameter int SUB_CYC = SUB_TICK_CYC
)(
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [DW-1:0] reg_rdata,
    input  wire logic          run_cmd,
    input  wire logic          power_loss,
    input  wire logic          undervoltage_indication,
    input  wire logic          overload_trip,
    input  wire logic          overcurrent_fault,
    input  wire logic          overvoltage_fault,
    input  wire logic          other_fault,
    input  wire logic          fault_reset,
    input  wire logic          ext_block_req,
    input  wire logic          encoder_feedback_card,
    input  wire logic [DW-1:0] encoder_freq,
    input  wire logic [7:0]    out_current_pct,
    input  wire logic [DW-1:0] torque_raw,
    input  wire logic [DW-1:0] slip_raw,
    output logic      [DW-1:0] out_freq,
    output logic               drive_en,
    output logic               dc_brake_en,
    output logic      [6:0]    dc_brake_level,
    output logic               output_block_wait,
    output logic               fault_active,
    output logic      [DW-1:0] torque_comp,
    output logic      [DW-1:0] slip_comp
);

    function automatic logic [DW-1:0] cfg_lo(input logic [AW-1:0] a);
        unique case (a)
            REG_TQ_TC:    cfg_lo = V_TQ_TC_MIN;
            REG_SLIP_TC:  cfg_lo = V_SL_TC_MIN;
            REG_PL_MAX_T: cfg_lo = V_ONE;
            REG_BLK_T:    cfg_lo = V_ONE;
            REG_SS_ILIM:  cfg_lo = V_ILIM_MIN;
            default:      cfg_lo = V_ZERO;
        endcase
    endfunction

    function automatic logic [DW-1:0] cfg_hi(input logic [AW-1:0] a);
        unique case (a)
            REG_TQ_TC, REG_SLIP_TC:       cfg_hi = V_TC_MAX;
            REG_DCB_LVL:                  cfg_hi = V_PCT_MAX;
            REG_DCB_T_RUN, REG_DCB_T_STP: cfg_hi = V_DCB_T_MAX;
            REG_PL_SEL:                   cfg_hi = V_TWO;
            REG_PL_MAX_T, REG_BLK_T:      cfg_hi = V_PL_T_MAX;
            REG_SS_ILIM:                  cfg_hi = V_ILIM_MAX;
            REG_AR_NUM:                   cfg_hi = V_AR_MAX;
            REG_AR_RST_T:                 cfg_hi = V_AR_T_MAX;
            REG_STOP_SEL:                 cfg_hi = V_THREE;
            default:                      cfg_hi = V_FREQ_MAX;
        endcase
    endfunction

    function automatic logic [DW-1:0] cfg_rst(input logic [AW-1:0] a);
        unique case (a)
            REG_TQ_TC:    cfg_rst = V_TQ_TC_RST;
            REG_SLIP_TC:  cfg_rst = V_SL_TC_RST;
            REG_PL_MAX_T: cfg_rst = V_PL_T_RST;
            REG_BLK_T:    cfg_rst = V_BLK_T_RST;
            REG_SS_ILIM:  cfg_rst = V_ILIM_RST;
            REG_AR_RST_T: cfg_rst = V_AR_T_RST;
            default:      cfg_rst = V_ZERO;
        endcase
    endfunction

    // Moves f toward t by at most s.
    function automatic logic [DW-1:0] step_to(input logic [DW-1:0] f, input logic [DW-1:0] t,
                                              input logic [DW-1:0] s);
        if (f < t)
            step_to = (t - f > s) ? f + s : t;
        else
            step_to = (f - t > s) ? f - s : t;
    endfunction

    // First-order step: moves one eighth of the error, at least one count.
    function automatic logic [DW-1:0] filt(input logic [DW-1:0] y, input logic [DW-1:0] x);
        logic [DW-1:0] d;
        d = (x > y) ? x - y : y - x;
        filt = step_to(y, x, ((d >> 3) != V_ZERO) ? d >> 3 : V_ONE);
    endfunction

    function automatic logic [DW-1:0] skip(input logic [DW-1:0] t, input logic [DW-1:0] hi,
                                           input logic [DW-1:0] lo);
        skip = (t >= lo && t <= hi && hi != V_ZERO) ? lo : t;
    endfunction

    function automatic logic [DW-1:0] dsec_ticks(input logic [DW-1:0] v);
        dsec_ticks = DW'(v * TICK_PER_DSEC);
    endfunction

    logic [DW-1:0] cfg_r [0:NCFG-1];
    drs_state_e    st_r;
    drs_state_e    st_nxt;
    logic [DW-1:0] tmr_r;
    logic [DW-1:0] tmr_nxt;
    logic [DW-1:0] freq_r;
    logic [DW-1:0] freq_nxt;
    logic [DW-1:0] save_r;
    logic [DW-1:0] save_nxt;
    logic [3:0]    left_r;
    logic [3:0]    left_nxt;
    logic          lock_r;
    logic          lock_nxt;
    logic          ar_clr;
    logic [DW-1:0] ar_sec_r;
    logic [15:0]   sub_cnt_r;
    logic [2:0]    sub8_r;
    logic [6:0]    tick_cnt_r;
    logic          sub_tick;
    logic          tick;
    logic          sec_tick;
    logic [DW-1:0] run_sec_r;
    logic [DW-1:0] run_min_r;
    logic [DW-1:0] run_day_r;
    logic [DW-1:0] tq_cnt_r;
    logic [DW-1:0] sl_cnt_r;
    logic [DW-1:0] rd_mux;

    wire           cfg_sel  = reg_addr < AW'(NCFG);
    wire           wr_ok    = reg_wr && cfg_sel && reg_wdata >= cfg_lo(reg_addr)
                              && reg_wdata <= cfg_hi(reg_addr);
    wire           wr_ar    = wr_ok && reg_addr == REG_AR_NUM;
    wire           clr_min  = reg_wr && reg_addr == REG_RUN_MIN && reg_wdata == V_ZERO;
    wire           clr_day  = reg_wr && reg_addr == REG_RUN_DAY && reg_wdata == V_ZERO;
    wire [DW-1:0]  target   = skip(skip(skip(cfg_r[REG_FREQ_CMD],
                                             cfg_r[REG_SKIP1_HI], cfg_r[REG_SKIP1_LO]),
                                        cfg_r[REG_SKIP2_HI], cfg_r[REG_SKIP2_LO]),
                                   cfg_r[REG_SKIP3_HI], cfg_r[REG_SKIP3_LO]);
    wire           ramp_stop = cfg_r[REG_STOP_SEL] == V_ZERO
                              || cfg_r[REG_STOP_SEL] == V_TWO;
    wire           driving  = st_r == ST_RUN || st_r == ST_DCB_START || st_r == ST_DECEL
                              || st_r == ST_DCB_STOP || st_r == ST_SEARCH;
    wire           trip_ocv = (overcurrent_fault || overvoltage_fault)
                              && (driving || st_r == ST_BLK_WAIT);
    wire           pl_resume = (cfg_r[REG_PL_SEL] != V_ZERO || encoder_feedback_card)
                              && cfg_r[REG_PL_MAX_T] <= V_PL_T_MAX
                              && undervoltage_indication;
    wire [DW-1:0]  pl_start = (cfg_r[REG_PL_SEL] == V_ONE) ? cfg_r[REG_FREQ_CMD]
                                                          : cfg_r[REG_FREQ_MIN];
    wire           ilim_low = {8'h00, out_current_pct} <= cfg_r[REG_SS_ILIM];
    wire           ar_quiet = ar_sec_r > cfg_r[REG_AR_RST_T];

    assign sub_tick = sub_cnt_r == 16'(SUB_CYC - 1);
    assign tick     = sub_tick && sub8_r == 3'(SUB_PER_TICK - 1);
    assign sec_tick = tick && tick_cnt_r == 7'(TICK_PER_SEC - 1);

    always_ff @(posedge clk)
    begin
        if (srst || sub_tick)
            sub_cnt_r <= '0;
        else
            sub_cnt_r <= sub_cnt_r + 16'h0001;
        if (srst)
            sub8_r <= '0;
        else if (sub_tick)
            sub8_r <= sub8_r + 3'h1;
        if (srst || sec_tick)
            tick_cnt_r <= '0;
        else if (tick)
            tick_cnt_r <= tick_cnt_r + 7'h01;
    end

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NCFG; i++)
        begin
            if (srst)
                cfg_r[i] <= cfg_rst(AW'(i));
            else if (wr_ok && reg_addr == AW'(i))
                cfg_r[i] <= reg_wdata;
        end
    end

    always_comb
    begin
        unique case (reg_addr)
            REG_RUN_MIN:  rd_mux = run_min_r;
            REG_RUN_DAY:  rd_mux = run_day_r;
            REG_STATUS:   rd_mux = {7'h00, left_r, lock_r, 4'(st_r)};
            REG_OUT_FREQ: rd_mux = freq_r;
            default:      rd_mux = cfg_sel ? cfg_r[reg_addr] : V_ZERO;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? rd_mux : V_ZERO;
    end

    // Sequencer. Fault outranks power loss, which outranks external block.
    always_comb
    begin
        st_nxt   = st_r;
        tmr_nxt  = tick ? tmr_r + V_ONE : tmr_r;
        freq_nxt = freq_r;
        save_nxt = save_r;
        left_nxt = ar_quiet ? cfg_r[REG_AR_NUM][3:0] : left_r;
        lock_nxt = lock_r && run_cmd;
        ar_clr   = 1'b0;
        if (trip_ocv)
        begin
            save_nxt = freq_r;
            freq_nxt = V_ZERO;
            tmr_nxt  = V_ZERO;
            if (cfg_r[REG_AR_NUM] != V_ZERO && left_r != 4'h0)
            begin
                left_nxt = left_r - 4'h1;
                ar_clr   = 1'b1;
                st_nxt   = ST_BLK_WAIT;
            end
            else
                st_nxt = ST_FAULT;
        end
        else if (other_fault && st_r != ST_FAULT)
        begin
            st_nxt   = ST_FAULT;
            freq_nxt = V_ZERO;
        end
        else if (power_loss && driving)
        begin
            save_nxt = freq_r;
            freq_nxt = V_ZERO;
            tmr_nxt  = V_ZERO;
            st_nxt   = ST_LOSS;
        end
        else if (ext_block_req && driving)
        begin
            save_nxt = freq_r;
            freq_nxt = V_ZERO;
            st_nxt   = ST_BLK_HOLD;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                    if (run_cmd && !lock_r)
                    begin
                        tmr_nxt  = V_ZERO;
                        freq_nxt = cfg_r[REG_FREQ_MIN];
                        st_nxt   = (cfg_r[REG_DCB_T_RUN] == V_ZERO) ? ST_RUN : ST_DCB_START;
                    end
                ST_DCB_START:
                    if (!run_cmd)
                        st_nxt = ST_IDLE;
                    else if (tmr_r >= dsec_ticks(cfg_r[REG_DCB_T_RUN]))
                        st_nxt = ST_RUN;
                ST_RUN:
                    if (!run_cmd)
                    begin
                        st_nxt   = ramp_stop ? ST_DECEL : ST_IDLE;
                        freq_nxt = ramp_stop ? freq_r : V_ZERO;
                    end
                    else if (tick)
                        freq_nxt = step_to(freq_r, target, RAMP_STEP);
                ST_DECEL:
                    if (run_cmd)
                        st_nxt = ST_RUN;
                    else if (cfg_r[REG_DCB_T_STP] != V_ZERO
                             && freq_r <= cfg_r[REG_DCB_FREQ])
                    begin
                        st_nxt   = ST_DCB_STOP;
                        tmr_nxt  = V_ZERO;
                        freq_nxt = V_ZERO;
                    end
                    else if (freq_r == V_ZERO)
                        st_nxt = ST_IDLE;
                    else if (tick)
                        freq_nxt = step_to(freq_r, V_ZERO, RAMP_STEP);
                ST_DCB_STOP:
                    if (tmr_r >= dsec_ticks(cfg_r[REG_DCB_T_STP]))
                        st_nxt = ST_IDLE;
                ST_LOSS:
                    if (!power_loss)
                    begin
                        tmr_nxt = V_ZERO;
                        if (overload_trip)
                            st_nxt = ST_IDLE;
                        else if (pl_resume)
                        begin
                            save_nxt = pl_start;
                            st_nxt   = ST_BLK_WAIT;
                        end
                        else
                        begin
                            lock_nxt = 1'b1;
                            st_nxt   = ST_IDLE;
                        end
                    end
                    else if (tmr_r >= dsec_ticks(cfg_r[REG_PL_MAX_T]))
                    begin
                        lock_nxt = 1'b1;
                        st_nxt   = ST_IDLE;
                    end
                ST_BLK_HOLD:
                    if (!ext_block_req)
                    begin
                        tmr_nxt = V_ZERO;
                        st_nxt  = ST_BLK_WAIT;
                    end
                ST_BLK_WAIT:
                    if (tmr_r >= dsec_ticks(cfg_r[REG_BLK_T]))
                    begin
                        freq_nxt = encoder_feedback_card ? encoder_freq : save_r;
                        st_nxt   = ST_SEARCH;
                    end
                ST_SEARCH:
                    if (ilim_low || freq_r == V_ZERO)
                        st_nxt = ST_RUN;
                    else if (tick)
                        freq_nxt = step_to(freq_r, V_ZERO, SEARCH_STEP);
                ST_FAULT:
                    if (fault_reset)
                    begin
                        left_nxt = cfg_r[REG_AR_NUM][3:0];
                        lock_nxt = 1'b1;
                        st_nxt   = ST_IDLE;
                    end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r   <= ST_IDLE;
            tmr_r  <= '0;
            freq_r <= '0;
            save_r <= '0;
            left_r <= '0;
            lock_r <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            tmr_r  <= tmr_nxt;
            freq_r <= freq_nxt;
            save_r <= save_nxt;
            left_r <= wr_ar ? reg_wdata[3:0] : left_nxt;
            lock_r <= lock_nxt;
        end
    end

    // Seconds since the last fault restart, saturating.
    always_ff @(posedge clk)
    begin
        if (srst || ar_clr)
            ar_sec_r <= '0;
        else if (sec_tick && ar_sec_r != V_SAT)
            ar_sec_r <= ar_sec_r + V_ONE;
    end

    // Operation time; the seconds part is never shown, so a partial minute is lost.
    always_ff @(posedge clk)
    begin
        if (srst || clr_min)
        begin
            run_sec_r <= '0;
            run_min_r <= '0;
        end
        else if (sec_tick && drive_en)
        begin
            run_sec_r <= (run_sec_r == V_SEC_LAST) ? V_ZERO : run_sec_r + V_ONE;
            if (run_sec_r == V_SEC_LAST)
                run_min_r <= (run_min_r == V_MIN_LAST) ? V_ZERO : run_min_r + V_ONE;
        end
        if (srst || clr_day)
            run_day_r <= '0;
        else if (sec_tick && drive_en && run_sec_r == V_SEC_LAST && run_min_r == V_MIN_LAST)
            run_day_r <= run_day_r + V_ONE;
    end

    // Each filter moves one eighth of its error every tc sub-ticks: time constant tc x 10 ms.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tq_cnt_r    <= '0;
            sl_cnt_r    <= '0;
            torque_comp <= '0;
            slip_comp   <= '0;
        end
        else if (sub_tick)
        begin
            tq_cnt_r <= (tq_cnt_r + V_ONE >= cfg_r[REG_TQ_TC]) ? V_ZERO : tq_cnt_r + V_ONE;
            sl_cnt_r <= (sl_cnt_r + V_ONE >= cfg_r[REG_SLIP_TC]) ? V_ZERO : sl_cnt_r + V_ONE;
            if (tq_cnt_r + V_ONE >= cfg_r[REG_TQ_TC])
                torque_comp <= filt(torque_comp, torque_raw);
            if (sl_cnt_r + V_ONE >= cfg_r[REG_SLIP_TC])
                slip_comp <= filt(slip_comp, slip_raw);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_freq          <= '0;
            drive_en          <= 1'b0;
            dc_brake_en       <= 1'b0;
            dc_brake_level    <= '0;
            output_block_wait <= 1'b0;
            fault_active      <= 1'b0;
        end
        else
        begin
            out_freq          <= freq_nxt;
            drive_en          <= st_nxt == ST_RUN || st_nxt == ST_DECEL || st_nxt == ST_SEARCH
                                 || st_nxt == ST_DCB_START || st_nxt == ST_DCB_STOP;
            dc_brake_en       <= st_nxt == ST_DCB_START || st_nxt == ST_DCB_STOP;
            dc_brake_level    <= cfg_r[REG_DCB_LVL][6:0];
            output_block_wait <= st_nxt == ST_LOSS || st_nxt == ST_BLK_HOLD
                                 || st_nxt == ST_BLK_WAIT;
            fault_active      <= st_nxt == ST_FAULT;
        end
    end

endmodule
`default_nettype wire

// File: drs_monitor.sv
// Concurrent checks on the sequencer outputs.
`timescale 1ns/100ps
`default_nettype none
module drs_monitor
    import drs_pkg::*;
(
    input wire logic          clk,
    input wire logic          srst,
    input wire logic          reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic          power_loss,
    input wire logic          overcurrent_fault,
    input wire logic          overvoltage_fault,
    input wire logic          other_fault,
    input wire logic [DW-1:0] out_freq,
    input wire logic          drive_en,
    input wire logic          dc_brake_en,
    input wire logic [6:0]    dc_brake_level,
    input wire logic          output_block_wait,
    input wire logic          fault_active
);
    logic [DW-1:0] pf;
    wire  [DW-1:0] dif = (out_freq > pf) ? out_freq - pf : pf - out_freq;
    always_ff @(posedge clk)
        pf <= out_freq;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_RD_ZERO: assert property (!$past(reg_rd) |-> reg_rdata == V_ZERO)
        else $error("read data outside its answer cycle");
    AST_BRK_DRV: assert property (dc_brake_en |-> drive_en && dc_brake_level <= 7'h64)
        else $error("brake without drive or level too high");
    AST_BLK_OFF: assert property (output_block_wait |-> !drive_en)
        else $error("output driven while blocked");
    AST_LOSS_BLK: assert property ($rose(power_loss) && drive_en && !fault_active
        && !overcurrent_fault && !overvoltage_fault && !other_fault |=> output_block_wait)
        else $error("power loss did not block output");
    AST_FLT_OFF: assert property (fault_active |-> !drive_en)
        else $error("output driven in fault state");
    AST_OTHER_FLT: assert property (other_fault ##1 1'b1 |-> fault_active)
        else $error("other trip did not fault");
    AST_RAMP: assert property (drive_en && $past(drive_en) && !dc_brake_en
        && !$past(dc_brake_en) |-> dif <= RAMP_STEP)
        else $error("frequency jumped while driving");
    AST_OC_ACT: assert property ($rose(overcurrent_fault) && drive_en
        |=> fault_active || output_block_wait)
        else $error("overcurrent not acted on");
endmodule
bind drs_sequencer drs_monitor mon (.*);
`default_nettype wire

// File: drs_motor_model.sv
// Behavioural motor that draws surge current while driven above its shaft speed.
`timescale 1ns/100ps
`default_nettype none
module drs_motor_model
    import drs_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          drive_en,
    input  wire logic [DW-1:0] out_freq,
    output logic      [DW-1:0] encoder_freq,
    output logic      [7:0]    out_current_pct
);
    logic [DW-1:0] spd_r = 16'h0000;
    wire           over  = drive_en && out_freq > spd_r;
    // The shaft freewheels unpowered and accelerates slower than the ramp.
    always_ff @(posedge clk)
        spd_r <= over ? spd_r + 16'h0001 : (drive_en ? out_freq : spd_r);
    assign encoder_freq    = spd_r;
    assign out_current_pct = over ? 8'hD2 : 8'h3C;
endmodule
`default_nettype wire

// File: tb_drs_sequencer.sv
// Register and sequencing tests of the restart and brake sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb_drs_sequencer
    import drs_pkg::*;
;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
`define PLS(s) @(posedge clk) s <= 1'b1; @(posedge clk) s <= 1'b0;
`define WT(c) for (w = 0; w < 6000 && !(c); w++) @(negedge clk);
    logic          clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, run_cmd = 0, power_loss = 0;
    logic          undervoltage_indication = 0, overload_trip = 0, overcurrent_fault = 0;
    logic          overvoltage_fault = 0, other_fault = 0, fault_reset = 0, ext_block_req = 0;
    logic          encoder_feedback_card = 0, drive_en, dc_brake_en, output_block_wait;
    logic          fault_active;
    logic [AW-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0, reg_rdata, out_freq, encoder_freq, torque_comp, slip_comp;
    logic [DW-1:0] torque_raw = 16'h0100, slip_raw = 16'h0200;
    logic [7:0]    out_current_pct;
    logic [6:0]    dc_brake_level;
    int            err_count = 0, n_checks = 0, cyc = 0, w;
    logic [AW-1:0] da [7] = '{REG_TQ_TC, REG_SLIP_TC, REG_PL_MAX_T, REG_BLK_T, REG_SS_ILIM,
                              REG_AR_RST_T, REG_DCB_LVL};
    logic [DW-1:0] dv [7] = '{V_TQ_TC_RST, V_SL_TC_RST, V_PL_T_RST, V_BLK_T_RST, V_ILIM_RST,
                              V_AR_T_RST, V_ZERO};
    logic [AW-1:0] wa [11] = '{REG_DCB_LVL, REG_DCB_T_RUN, REG_DCB_T_STP, REG_DCB_FREQ,
        REG_PL_SEL, REG_FREQ_MIN, REG_FREQ_CMD, REG_SKIP1_HI, REG_SKIP1_LO, REG_AR_NUM,
        REG_SS_ILIM};
    logic [DW-1:0] wv [11] = '{16'h0040, V_ONE, V_ONE, 16'h0400, V_ONE, 16'h0100,
        16'h0800, 16'h0900, 16'h0700, V_ONE, V_ILIM_MAX};

    drs_sequencer #(.SUB_CYC(4)) dut (.*);
    drs_motor_model motor (.*);

    always #12.5 clk = ~clk;

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) `CHK("reg_rdata", e, reg_rdata)
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        foreach (da[i]) rd(da[i], dv[i]);
        wr(REG_SS_ILIM, 16'h001D);
        rd(REG_SS_ILIM, V_ILIM_RST);
        wr(REG_RUN_MIN, 16'h0005);
        rd(REG_RUN_MIN, V_ZERO);
        rd(5'h1F, V_ZERO);
        foreach (wa[i]) wr(wa[i], wv[i]);
        rd(REG_SS_ILIM, V_ILIM_MAX);
        @(posedge clk) run_cmd <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK("dc_brake_level", 7'h40, dc_brake_level)
        `WT(!dc_brake_en)
        `CHK("start brake", 1'b1, w > 280 && w < 360)
        `CHK("out_freq", 16'h0100, out_freq)
        `WT(out_freq == 16'h0700)
        repeat (300) @(negedge clk);
        `CHK("out_freq", 16'h0700, out_freq)
        @(posedge clk) {power_loss, undervoltage_indication} <= 2'b11;
        repeat (2) @(negedge clk);
        `CHK("output_block_wait", 1'b1, output_block_wait)
        repeat (100) @(posedge clk);
        power_loss <= 1'b0;
        `WT(!output_block_wait)
        `CHK("block time", 1'b1, w > 1550 && w < 1700)
        `CHK("out_freq", 16'h0800, out_freq)
        `WT(out_freq == 16'h0700 && drive_en)
        `CHK("out_freq", 16'h0700, out_freq)
        @(posedge clk) {run_cmd, undervoltage_indication} <= 2'b00;
        `WT(out_freq <= 16'h0400)
        `CHK("brake point", 1'b1, out_freq > 16'h03CE && !dc_brake_en)
        @(negedge clk) `CHK("dc_brake_en", 1'b1, dc_brake_en)
        `WT(!drive_en)
        @(posedge clk) run_cmd <= 1'b1;
        `WT(out_freq == 16'h0700)
        `PLS(overcurrent_fault)
        @(negedge clk) `CHK("output_block_wait", 1'b1, output_block_wait)
        `WT(!output_block_wait)
        `CHK("out_freq", 16'h0700, out_freq)
        repeat (40) @(posedge clk);
        `PLS(overvoltage_fault)
        @(negedge clk) `CHK("fault_active", 1'b1, fault_active)
        `PLS(other_fault)
        `PLS(fault_reset)
        @(negedge clk) `CHK("fault_active", 1'b0, fault_active)
        `CHK("comp", 32'h0100_0200, {torque_comp, slip_comp})
        print_verdict();
    end
endmodule
`default_nettype wire
